// ==== touch_ctl_pkg.sv ====
// Shared constants for the second control register of the touch converter controller
package touch_ctl_pkg;
	// Register map
	localparam logic [7:0] CTL2_ADDR = 8'h02;
	localparam logic [15:0] CTL2_RESET = 16'h4040;
	// Field positions
	localparam int POWER_HI = 15;
	localparam int POWER_LO = 14;
	localparam int PIN_EN_BIT = 13;
	localparam int PIN_LEVEL_BIT = 12;
	localparam int PIN_DIR_BIT = 11;
	localparam int PIN_POL_BIT = 10;
	localparam int SINGLE_END_BIT = 9;
	localparam int AVG_HI = 8;
	localparam int AVG_LO = 7;
	localparam int MED_HI = 6;
	localparam int MED_LO = 5;
	localparam int SOFT_RST_BIT = 4;
	localparam int DELAY_HI = 3;
	localparam int DELAY_LO = 0;
	// Power management codes
	localparam logic [1:0] PWR_OFF = 2'h0;
	localparam logic [1:0] PWR_ALWAYS_ON = 2'h2;
	// Conversion mode codes
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_SLAVE = 2'h2;
	localparam logic [1:0] MODE_MASTER = 2'h3;
	// Settling delay timing
	localparam int CLK_MHZ = 100;
	localparam int DELAY_STEP_US = 128;
	localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLK_MHZ;
	localparam int DELAY_CNT_W = 24;

	typedef enum logic [1:0] {
		PIN_ANALOG,
		PIN_OUTPUT,
		PIN_INPUT
	} pin_use_t;

	// Averaging length in samples; 00 means one sample when median is off
	function automatic logic [4:0] avg_len(input logic [1:0] code, input logic [1:0] middle_value_filter_size);
		case (code)
			2'h0: avg_len = (middle_value_filter_size == 2'h0) ? 5'h01 : 5'h02;
			2'h1: avg_len = 5'h04;
			2'h2: avg_len = 5'h08;
			default: avg_len = 5'h10;
		endcase
	endfunction

	function automatic logic [4:0] med_len(input logic [1:0] code);
		case (code)
			2'h0: med_len = 5'h00;
			2'h1: med_len = 5'h04;
			2'h2: med_len = 5'h08;
			default: med_len = 5'h10;
		endcase
	endfunction
endpackage

// ==== conv_ctl_if.sv ====
// Control signals shared between the register bank, the power manager and the settling timer
`timescale 1ns/1ps
interface conv_ctl_if;
	logic soft_clear;
	logic [1:0] power_state_select;
	logic [1:0] conv_mode;
	logic touch;
	logic conv_active;
	logic adc_pwr;
	logic osc_pwr;
	logic bias_pwr;
	logic temp_pwr;
	logic [3:0] settling_delay;
	logic start;
	logic need_settle;
	logic go;
	logic waiting;

	modport bank (output soft_clear, power_state_select, conv_mode, touch, conv_active, settling_delay,
		start, need_settle, input adc_pwr, osc_pwr, bias_pwr, temp_pwr, go, waiting);
	modport power (input soft_clear, power_state_select, conv_mode, touch, conv_active,
		output adc_pwr, osc_pwr, bias_pwr, temp_pwr);
	modport timer (input soft_clear, settling_delay, start, need_settle, output go, waiting);
endinterface

// ==== power_manager.sv ====
// Analog block power enables chosen from power state and conversion mode
`timescale 1ns/1ps
module power_manager (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Control
	conv_ctl_if.power ctl
);
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl.adc_pwr <= 1'b0;
			ctl.osc_pwr <= 1'b0;
			ctl.bias_pwr <= 1'b0;
			ctl.temp_pwr <= 1'b0;
		end else if (ctl.soft_clear || ctl.power_state_select == touch_ctl_pkg::PWR_OFF) begin
			ctl.adc_pwr <= 1'b0; // see R1
			ctl.osc_pwr <= 1'b0;
			ctl.bias_pwr <= 1'b0;
			ctl.temp_pwr <= 1'b0;
		end else if (ctl.power_state_select == touch_ctl_pkg::PWR_ALWAYS_ON) begin
			ctl.adc_pwr <= 1'b1; // see R4
			ctl.osc_pwr <= 1'b1;
			ctl.bias_pwr <= 1'b1;
			ctl.temp_pwr <= ctl.conv_active;
		end else begin
			case (ctl.conv_mode) // see R14
				touch_ctl_pkg::MODE_MASTER: begin
					// Everything sleeps until a touch wakes it
					ctl.adc_pwr <= ctl.touch || ctl.conv_active; // see R2
					ctl.osc_pwr <= ctl.touch || ctl.conv_active;
					ctl.bias_pwr <= ctl.touch || ctl.conv_active;
					ctl.temp_pwr <= ctl.touch || ctl.conv_active;
				end
				touch_ctl_pkg::MODE_SLAVE, touch_ctl_pkg::MODE_SINGLE: begin
					// Oscillator and bias keep running for the interval timer
					ctl.adc_pwr <= ctl.conv_active; // see R3
					ctl.osc_pwr <= 1'b1;
					ctl.bias_pwr <= 1'b1;
					ctl.temp_pwr <= ctl.conv_active;
				end
				default: begin
					ctl.adc_pwr <= 1'b0;
					ctl.osc_pwr <= 1'b0;
					ctl.bias_pwr <= 1'b0;
					ctl.temp_pwr <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ==== settle_timer.sv ====
// First conversion delay: holds a conversion request for (code + 1) delay steps
`timescale 1ns/1ps
module settle_timer #(
	parameter int STEP_CYCLES = touch_ctl_pkg::DELAY_STEP_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Control
	conv_ctl_if.timer ctl
);
	typedef enum logic {
		T_IDLE,
		T_WAIT
	} tstate_t;

	localparam logic [touch_ctl_pkg::DELAY_CNT_W-1:0] STEP = STEP_CYCLES[touch_ctl_pkg::DELAY_CNT_W-1:0];

	tstate_t state_r;
	logic [touch_ctl_pkg::DELAY_CNT_W-1:0] cnt_r;
	logic [4:0] steps_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= T_IDLE;
			cnt_r <= '0;
			steps_r <= '0;
			ctl.go <= 1'b0;
		end else if (ctl.soft_clear) begin
			state_r <= T_IDLE;
			cnt_r <= '0;
			steps_r <= '0;
			ctl.go <= 1'b0;
		end else begin
			ctl.go <= 1'b0;
			case (state_r)
				T_IDLE: begin
					if (ctl.start && ctl.need_settle) begin
						state_r <= T_WAIT; // see R12
						cnt_r <= STEP - 1'b1;
						steps_r <= {1'b0, ctl.settling_delay}; // see R11
					end else if (ctl.start) begin
						ctl.go <= 1'b1;
					end
				end
				default: begin
					if (cnt_r != '0) begin
						cnt_r <= cnt_r - 1'b1;
					end else if (steps_r != '0) begin
						steps_r <= steps_r - 1'b1;
						cnt_r <= STEP - 1'b1;
					end else begin
						state_r <= T_IDLE;
						ctl.go <= 1'b1;
					end
				end
			endcase
		end
	end

	assign ctl.waiting = (state_r == T_WAIT);
endmodule

// ==== touch_adc_control_two.sv ====
// Second control register: power policy, spare pin, filter sizes, soft reset and settling delay
// Function
// R1: Power code 00 shuts every analog block down
// R2: Master mode sleeps all blocks until touch
// R3: Slave/single keep oscillator, bias; converter on demand
// R4: Power code 10 keeps converter, bias, oscillator on
// R5: Bit 13 turns shared pin into spare pin
// R6: Bit 10 sets spare pin active level
// R7: Bit 9 picks single-ended over ratiometric conversion
// R8: Bits 8:7 set averaging length
// R9: Bits 6:5 set median window or off
// R10: Writing one to bit 4 resets logic
// R11: Bits 3:0 give delay in 128 us steps
// R12: Delay precedes touch channels and first conversion
// R13: Spare pin enabled blocks aux and battery selection
// R14: Conversion mode input steers power behaviour
// R15: Direction bit picks output or input; level follows
`timescale 1ns/1ps
module touch_adc_control_two #(
	parameter int DELAY_STEP_CYCLES = touch_ctl_pkg::DELAY_STEP_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Register access from the serial host interface
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	// Sequencer status
	input wire logic [1:0] i_conv_mode,
	input wire logic i_touch,
	input wire logic i_conv_active,
	input wire logic i_conv_request,
	input wire logic i_touch_channel,
	input wire logic i_aux_select,
	input wire logic i_vbat_select,
	// Sequencer control
	output logic o_conv_go,
	output logic o_settling,
	output logic o_digital_reset,
	output logic o_aux_measure,
	output logic o_vbat_measure,
	// Conversion setup
	output logic o_single_ended,
	output logic [4:0] o_average_len,
	output logic [4:0] o_median_len,
	// Analog power enables
	output logic o_adc_power,
	output logic o_osc_power,
	output logic o_bias_power,
	output logic o_temp_power,
	// Shared auxiliary / spare pin
	input wire logic i_spare_pin,
	output logic o_spare_pin,
	output logic o_spare_pin_oe,
	output logic o_spare_pin_enabled
);
	conv_ctl_if ctl ();

	logic [1:0] power_state_select_r;
	logic spare_pin_enable_r;
	logic spare_pin_level_r;
	logic spare_pin_dir_r;
	logic spare_pin_polarity_r;
	logic single_ended_select_r;
	logic [1:0] averaging_count_r;
	logic [1:0] middle_value_filter_size_r;
	logic [3:0] settling_delay_r;
	logic soft_reset_r;
	logic pin_in_r;
	logic first_conv_r;
	logic wr_hit;
	logic rd_hit;
	logic [15:0] rd_word;
	touch_ctl_pkg::pin_use_t pin_use;

	assign wr_hit = i_reg_wr && (i_reg_addr == touch_ctl_pkg::CTL2_ADDR);
	assign rd_hit = i_reg_rd && (i_reg_addr == touch_ctl_pkg::CTL2_ADDR);

	always_comb begin
		if (!spare_pin_enable_r) begin
			pin_use = touch_ctl_pkg::PIN_ANALOG;
		end else if (spare_pin_dir_r) begin
			pin_use = touch_ctl_pkg::PIN_INPUT;
		end else begin
			pin_use = touch_ctl_pkg::PIN_OUTPUT;
		end
	end

	// Soft reset: one-cycle pulse, a cycle after the write, that clears the submodules; the register clears on the write itself
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			soft_reset_r <= 1'b0;
		end else begin
			soft_reset_r <= wr_hit && i_reg_wdata[touch_ctl_pkg::SOFT_RST_BIT]; // see R10
		end
	end

	// Register fields; the reset bit itself is never stored and reads back as zero
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			power_state_select_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::POWER_HI:touch_ctl_pkg::POWER_LO];
			spare_pin_enable_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_EN_BIT];
			spare_pin_level_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_LEVEL_BIT];
			spare_pin_dir_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_DIR_BIT];
			spare_pin_polarity_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_POL_BIT];
			single_ended_select_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::SINGLE_END_BIT];
			averaging_count_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::AVG_HI:touch_ctl_pkg::AVG_LO];
			middle_value_filter_size_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::MED_HI:touch_ctl_pkg::MED_LO];
			settling_delay_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::DELAY_HI:touch_ctl_pkg::DELAY_LO];
		end else if (wr_hit && i_reg_wdata[touch_ctl_pkg::SOFT_RST_BIT]) begin
			// Whole register returns to its default, the rest of the written word is dropped
			power_state_select_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::POWER_HI:touch_ctl_pkg::POWER_LO]; // see R10
			spare_pin_enable_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_EN_BIT];
			spare_pin_level_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_LEVEL_BIT];
			spare_pin_dir_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_DIR_BIT];
			spare_pin_polarity_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::PIN_POL_BIT];
			single_ended_select_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::SINGLE_END_BIT];
			averaging_count_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::AVG_HI:touch_ctl_pkg::AVG_LO];
			middle_value_filter_size_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::MED_HI:touch_ctl_pkg::MED_LO];
			settling_delay_r <= touch_ctl_pkg::CTL2_RESET[touch_ctl_pkg::DELAY_HI:touch_ctl_pkg::DELAY_LO];
		end else if (wr_hit) begin
			power_state_select_r <= i_reg_wdata[touch_ctl_pkg::POWER_HI:touch_ctl_pkg::POWER_LO];
			spare_pin_enable_r <= i_reg_wdata[touch_ctl_pkg::PIN_EN_BIT]; // see R5
			spare_pin_level_r <= i_reg_wdata[touch_ctl_pkg::PIN_LEVEL_BIT];
			spare_pin_dir_r <= i_reg_wdata[touch_ctl_pkg::PIN_DIR_BIT]; // see R15
			spare_pin_polarity_r <= i_reg_wdata[touch_ctl_pkg::PIN_POL_BIT]; // see R6
			single_ended_select_r <= i_reg_wdata[touch_ctl_pkg::SINGLE_END_BIT]; // see R7
			averaging_count_r <= i_reg_wdata[touch_ctl_pkg::AVG_HI:touch_ctl_pkg::AVG_LO];
			middle_value_filter_size_r <= i_reg_wdata[touch_ctl_pkg::MED_HI:touch_ctl_pkg::MED_LO];
			settling_delay_r <= i_reg_wdata[touch_ctl_pkg::DELAY_HI:touch_ctl_pkg::DELAY_LO]; // see R11
		end
	end

	// Input level converted to logical sense through the polarity bit
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_in_r <= 1'b0;
		end else begin
			pin_in_r <= spare_pin_polarity_r ? i_spare_pin : ~i_spare_pin; // see R6
		end
	end

	// Spare pin drive; pad is released whenever it is analog or an input
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_spare_pin <= 1'b0;
			o_spare_pin_oe <= 1'b0;
			o_spare_pin_enabled <= 1'b0;
		end else begin
			o_spare_pin_enabled <= spare_pin_enable_r; // see R5
			o_spare_pin_oe <= (pin_use == touch_ctl_pkg::PIN_OUTPUT); // see R15
			o_spare_pin <= (pin_use == touch_ctl_pkg::PIN_OUTPUT) &&
				(spare_pin_polarity_r ? spare_pin_level_r : ~spare_pin_level_r); // see R6
		end
	end

	// Channel gating: battery wins over aux, both are blocked by the spare pin
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_aux_measure <= 1'b0;
			o_vbat_measure <= 1'b0;
		end else begin
			o_aux_measure <= !spare_pin_enable_r && i_aux_select && !i_vbat_select; // see R13
			o_vbat_measure <= !spare_pin_enable_r && i_vbat_select; // see R13
		end
	end

	// Conversion setup decoded for the filter and converter
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_single_ended <= 1'b0;
			o_average_len <= 5'h00;
			o_median_len <= 5'h00;
		end else begin
			o_single_ended <= single_ended_select_r; // see R7
			o_average_len <= touch_ctl_pkg::avg_len(averaging_count_r, middle_value_filter_size_r); // see R8
			o_median_len <= touch_ctl_pkg::med_len(middle_value_filter_size_r); // see R9
		end
	end

	// First conversion after the converter was asleep always waits for power-up
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_conv_r <= 1'b1;
		end else if (soft_reset_r || !ctl.adc_pwr) begin
			first_conv_r <= 1'b1;
		end else if (ctl.go) begin
			first_conv_r <= 1'b0; // see R12
		end
	end

	assign ctl.soft_clear = soft_reset_r;
	assign ctl.power_state_select = power_state_select_r;
	assign ctl.conv_mode = i_conv_mode; // see R14
	assign ctl.touch = i_touch;
	assign ctl.conv_active = i_conv_active;
	assign ctl.settling_delay = settling_delay_r;
	assign ctl.start = i_conv_request && !ctl.waiting;
	assign ctl.need_settle = i_touch_channel || first_conv_r; // see R12

	power_manager u_power (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.ctl(ctl.power)
	);

	settle_timer #(
		.STEP_CYCLES(DELAY_STEP_CYCLES)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.ctl(ctl.timer)
	);

	// Sequencer and power outputs re-timed so every port leaves a flop here
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_conv_go <= 1'b0;
			o_settling <= 1'b0;
			o_digital_reset <= 1'b0;
			o_adc_power <= 1'b0;
			o_osc_power <= 1'b0;
			o_bias_power <= 1'b0;
			o_temp_power <= 1'b0;
		end else begin
			o_conv_go <= ctl.go;
			o_settling <= ctl.waiting;
			o_digital_reset <= soft_reset_r; // see R10
			o_adc_power <= ctl.adc_pwr;
			o_osc_power <= ctl.osc_pwr;
			o_bias_power <= ctl.bias_pwr;
			o_temp_power <= ctl.temp_pwr;
		end
	end

	// Read back; the data bit shows the sampled pin while it is an input
	always_comb begin
		rd_word = '0;
		rd_word[touch_ctl_pkg::POWER_HI:touch_ctl_pkg::POWER_LO] = power_state_select_r;
		rd_word[touch_ctl_pkg::PIN_EN_BIT] = spare_pin_enable_r;
		rd_word[touch_ctl_pkg::PIN_LEVEL_BIT] =
			(pin_use == touch_ctl_pkg::PIN_INPUT) ? pin_in_r : spare_pin_level_r; // see R15
		rd_word[touch_ctl_pkg::PIN_DIR_BIT] = spare_pin_dir_r;
		rd_word[touch_ctl_pkg::PIN_POL_BIT] = spare_pin_polarity_r;
		rd_word[touch_ctl_pkg::SINGLE_END_BIT] = single_ended_select_r;
		rd_word[touch_ctl_pkg::AVG_HI:touch_ctl_pkg::AVG_LO] = averaging_count_r;
		rd_word[touch_ctl_pkg::MED_HI:touch_ctl_pkg::MED_LO] = middle_value_filter_size_r;
		rd_word[touch_ctl_pkg::DELAY_HI:touch_ctl_pkg::DELAY_LO] = settling_delay_r;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 16'h0000;
		end else if (rd_hit) begin
			o_reg_rdata <= rd_word;
		end else if (i_reg_rd) begin
			o_reg_rdata <= 16'h0000;
		end
	end
endmodule

// ==== touch_adc_control_two_chk.sv ====
// Concurrent checks on the ports of the second control register block
`timescale 1ns/1ps
module touch_adc_control_two_chk #(
	parameter int DELAY_STEP_CYCLES = 4
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Register access
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] o_reg_rdata,
	// Sequencer
	input wire logic i_aux_select,
	input wire logic i_vbat_select,
	input wire logic o_conv_go,
	input wire logic o_digital_reset,
	input wire logic o_aux_measure,
	input wire logic o_vbat_measure,
	input wire logic [4:0] o_average_len,
	input wire logic [4:0] o_median_len,
	// Power and pin
	input wire logic o_adc_power,
	input wire logic o_osc_power,
	input wire logic o_bias_power,
	input wire logic o_temp_power,
	input wire logic o_spare_pin_oe,
	input wire logic o_spare_pin_enabled
);
	logic soft_wr;
	assign soft_wr = i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[4];
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	AST_PIN_ANALOG: assert property (!o_spare_pin_enabled [*2] |-> !o_spare_pin_oe)
		else $error("pin driven while in analog use");
	AST_AUX_VBAT_ONE: assert property (!(o_aux_measure && o_vbat_measure))
		else $error("aux and vbat measured together");
	AST_AUX_CAUSE: assert property (o_aux_measure |-> $past(i_aux_select) && !$past(i_vbat_select))
		else $error("aux measured without its selection");
	AST_SOFT_ONE: assert property (o_digital_reset |=> !o_digital_reset)
		else $error("digital reset pulse too long");
	AST_SOFT_CAUSE: assert property (o_digital_reset |-> $past(soft_wr, 2))
		else $error("digital reset without soft reset write");
	AST_GO_ONE: assert property (o_conv_go |=> !o_conv_go)
		else $error("conversion start longer than one cycle");
	AST_TEMP_ADC: assert property (o_temp_power |-> o_adc_power)
		else $error("temperature sensor on with converter off");
	AST_ADC_CLOCKS: assert property (o_adc_power |-> o_osc_power && o_bias_power)
		else $error("converter on without oscillator and bias");
	AST_AVG_ONE: assert property (o_average_len == 5'h01 |-> o_median_len == 5'h00)
		else $error("single sample with median filter on");
	AST_RDATA_HOLD: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
		else $error("read data changed without a read");
	COV_SOFT: cover property (o_digital_reset);
	COV_GO: cover property (o_conv_go);
	COV_PIN: cover property (o_spare_pin_oe);
endmodule

bind touch_adc_control_two touch_adc_control_two_chk #(.DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)) chk_u (
	.i_sys_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
	.i_aux_select, .i_vbat_select, .o_conv_go, .o_digital_reset, .o_aux_measure, .o_vbat_measure,
	.o_average_len, .o_median_len, .o_adc_power, .o_osc_power, .o_bias_power, .o_temp_power,
	.o_spare_pin_oe, .o_spare_pin_enabled);

// ==== touch_adc_control_two_test.sv ====
// Self-checking testbench for the second control register block
`timescale 1ns/1ps
module touch_adc_control_two_test;
	// Short delay step keeps the settling waits brief
	localparam int STEP = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0, rd = 1'b0, req = 1'b0, tch = 1'b0, touch = 1'b0, act = 1'b0;
	logic auxs = 1'b0, vbs = 1'b0, pin_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic [1:0] mode = 2'h0;
	logic [15:0] rdata;
	logic go, setl, dres, auxm, vbm, se, pa, po, pb, pt, pout, poe, pen;
	logic [4:0] avl, mdl;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;

	touch_adc_control_two #(.DELAY_STEP_CYCLES(STEP)) dut_u (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_conv_mode(mode), .i_touch(touch),
		.i_conv_active(act), .i_conv_request(req), .i_touch_channel(tch), .i_aux_select(auxs),
		.i_vbat_select(vbs), .o_conv_go(go), .o_settling(setl), .o_digital_reset(dres),
		.o_aux_measure(auxm), .o_vbat_measure(vbm), .o_single_ended(se), .o_average_len(avl),
		.o_median_len(mdl), .o_adc_power(pa), .o_osc_power(po), .o_bias_power(pb), .o_temp_power(pt),
		.i_spare_pin(pin_in), .o_spare_pin(pout), .o_spare_pin_oe(poe), .o_spare_pin_enabled(pen));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask

	function automatic logic [3:0] pwr_exp(input logic [1:0] p, input logic [1:0] m, input logic t, input logic a);
		if (p == 2'h0) return 4'h0;
		if (p == 2'h2) return {3'b111, a};
		case (m)
			2'h3: return {4{t | a}};
			2'h0: return 4'h0;
			default: return {a, 2'b11, a};
		endcase
	endfunction

	// A write elsewhere must leave this register at its default
	task automatic t_defaults();
		logic [15:0] r;
		reg_wr(8'h03, 16'hFFFF);
		reg_rd(8'h02, r);
		check_val("reset word", 16'h4040, r);
		check_val("median len", 16'h0008, {11'h000, mdl});
		check_val("average len", 16'h0002, {11'h000, avl});
		check_val("pin state", 16'h0000, {14'h0000, pen, poe});
	endtask

	task automatic t_filters();
		logic [15:0] w, r;
		logic [4:0] ea, em;
		for (int c = 0; c < 32; c++) begin
			w = {6'h00, c[0], c[2:1], c[4:3], 5'h00};
			ea = (c[2:1] == 0) ? ((c[4:3] == 0) ? 5'h01 : 5'h02) : 5'h01 << (c[2:1] + 1);
			em = (c[4:3] == 0) ? 5'h00 : 5'h01 << (c[4:3] + 1);
			reg_wr(8'h02, w);
			idle(3);
			check_val("average len", {11'h000, ea}, {11'h000, avl});
			check_val("median len", {11'h000, em}, {11'h000, mdl});
			check_val("single ended", {15'h0000, c[0]}, {15'h0000, se});
			reg_rd(8'h02, r);
			check_val("readback", w, r);
		end
	endtask

	task automatic t_pin();
		logic [15:0] r;
		reg_wr(8'h02, 16'h3400);
		idle(2);
		check_val("pin out active high", 16'h0007, {13'h0000, pen, poe, pout});
		reg_wr(8'h02, 16'h3000);
		idle(2);
		check_val("pin out active low", 16'h0006, {13'h0000, pen, poe, pout});
		reg_wr(8'h02, 16'h2C00);
		pin_in = 1'b1;
		idle(3);
		reg_rd(8'h02, r);
		check_val("pin input", 16'h0001, {14'h0000, poe, r[12]});
		auxs = 1'b1;
		vbs = 1'b1;
		idle(3);
		check_val("aux vbat gated", 16'h0000, {14'h0000, auxm, vbm});
		reg_wr(8'h02, 16'h0000);
		idle(3);
		check_val("vbat only", 16'h0001, {14'h0000, auxm, vbm});
		vbs = 1'b0;
		idle(3);
		check_val("aux only", 16'h0002, {14'h0000, auxm, vbm});
		auxs = 1'b0;
	endtask

	task automatic t_power();
		for (int i = 0; i < 64; i++) begin
			reg_wr(8'h02, {i[5:4], 14'h0000});
			mode = i[3:2];
			touch = i[1];
			act = i[0];
			idle(4);
			check_val("power", {12'h000, pwr_exp(i[5:4], i[3:2], i[1], i[0])}, {12'h000, pa, po, pb, pt});
		end
	endtask

	task automatic t_soft();
		logic [15:0] r;
		int n;
		reg_wr(8'h02, 16'h0283);
		reg_wr(8'h02, 16'h8010);
		n = 0;
		repeat (4) begin
			@(negedge clk);
			if (dres === 1'b1) n++;
		end
		check_val("reset pulses", 16'h0001, n[15:0]);
		reg_rd(8'h02, r);
		check_val("word after soft reset", 16'h4040, r);
	endtask

	// First request settles and a request during the wait is dropped; the next starts at once
	task automatic t_settle();
		int n;
		int extra;
		logic seen;
		reg_wr(8'h02, 16'h8002);
		idle(4);
		for (int k = 0; k < 2; k++) begin
			tch = (k == 0);
			req = 1'b1;
			@(negedge clk);
			req = 1'b0;
			n = 0;
			seen = 1'b0;
			while (go !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
				seen |= (setl === 1'b1);
				req = (k == 0 && n == 3);
			end
			req = 1'b0;
			if (k == 0) begin
				check_val("settle window", 16'h0001, {15'h0000, n >= 3 * STEP && n <= 3 * STEP + 4});
				check_val("settling flag", 16'h0001, {15'h0000, seen});
			end else begin
				check_val("direct start", 16'h0001, n[15:0]);
			end
			extra = 0;
			repeat (3 * STEP + 8) begin
				@(negedge clk);
				if (go === 1'b1) extra++;
			end
			check_val("extra starts", 16'h0000, extra[15:0]);
		end
	endtask

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_defaults();
		t_filters();
		t_pin();
		t_power();
		t_soft();
		t_settle();
		conclude();
	end
endmodule
